// *** common/sdwl_pkg.sv ***
// package: constants, field layout and timing for the serial dac word loader
package sdwl_pkg;
    // ==========================================================
    // word format
    localparam int WORD_W       = 16;
    localparam int BYTE_W       = 8;
    localparam int CNT_W        = 4;
    localparam int NUM_CH       = 8;
    localparam int CH_W         = 3;
    localparam int MAIN_W       = 10;
    localparam int FINE_W       = 8;
    localparam int SYS_W        = 13;
    // type bits: 15 fine, 14 channel control, 13 main, none set: system
    localparam int TYPE_FINE_BIT = 15;
    localparam int TYPE_CHAN_BIT = 14;
    localparam int TYPE_MAIN_BIT = 13;
    localparam int CH_LSB        = 10;
    // system control payload bits
    localparam int SYS_STANDBY_BIT  = 0;
    localparam int SYS_PDOWN_BIT    = 1;
    localparam int SYS_OFFBIN_BIT   = 5;
    localparam logic [SYS_W-1:0] SYS_RESET = 13'h0000;
    // offset binary midscale codes, and the channel control reset value
    localparam logic [MAIN_W-1:0] MAIN_MID = 10'h200;
    localparam logic [FINE_W-1:0] FINE_MID = 8'h80;
    localparam logic [MAIN_W-1:0] CHAN_RESET = 10'h000;
    // ==========================================================
    // host command port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] HOST_DATA_OFS   = 4'h0;
    localparam logic [ADDR_W-1:0] HOST_CTRL_OFS   = 4'h4;
    localparam logic [ADDR_W-1:0] HOST_STATUS_OFS = 4'h8;
    localparam int CTRL_LOAD_N_BIT  = 0;
    localparam int CTRL_CLEAR_N_BIT = 1;
    localparam int CTRL_LSBF_BIT    = 2;
    localparam int CTRL_BYTE_BIT    = 3;
    localparam int CTRL_W           = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3;
    // ==========================================================
    // timing: serial clock half period and byte gap, in clock cycles
    localparam int PH_W     = 4;
    localparam logic [PH_W-1:0] HALF_CYC = 4'h2;
    localparam logic [PH_W-1:0] GAP_CYC  = 4'h4;
endpackage

// *** common/sdwl_link_if.sv ***
// interface: serial link between host controller and dac word loader
`timescale 1ns/100ps
interface sdwl_link_if;
    logic serial_clock_in;
    logic serial_data_in;
    logic frame_sync_n;
    logic output_load_strobe_n;
    logic hard_clear_n;
    modport host (
        output serial_clock_in,
        output serial_data_in,
        output frame_sync_n,
        output output_load_strobe_n,
        output hard_clear_n
    );
    modport dac (
        input serial_clock_in,
        input serial_data_in,
        input frame_sync_n,
        input output_load_strobe_n,
        input hard_clear_n
    );
endinterface // sdwl_link_if

// *** logic/sdwl_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sdwl_sync (
    // clock
    input  wire logic clk,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    logic meta_r;
    // ==========================================================
    // meta_r is read only by dout
    always_ff @(posedge clk) begin
        meta_r <= din;
        dout   <= meta_r;
    end
endmodule // sdwl_sync

// *** logic/sdwl_device.sv ***
// dac end: serial word receiver, register decode and output load
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module sdwl_device
    import sdwl_pkg::*;
(
    // system clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset,
    // serial link
    sdwl_link_if.dac                     link,
    // converter codes
    output logic [MAIN_W-1:0]            main_code_value [NUM_CH],
    output logic [FINE_W-1:0]            fine_code_value [NUM_CH],
    // configuration state
    output logic [MAIN_W-1:0]            chan_ctrl       [NUM_CH],
    output logic                         offset_binary,
    output logic                         standby,
    output logic                         powerdown,
    // one-cycle pulse when a decoded word is applied
    output logic                         word_applied
);
    // ==========================================================
    // decode helpers
    typedef enum {SDWL_K_SYS, SDWL_K_CHAN, SDWL_K_MAIN,
                  SDWL_K_FINE} sdwl_kind_e;

    function automatic sdwl_kind_e word_kind(input logic [WORD_W-1:0] w);
        if (w[TYPE_FINE_BIT])
            return SDWL_K_FINE;
        else if (w[TYPE_CHAN_BIT])
            return SDWL_K_CHAN;
        else if (w[TYPE_MAIN_BIT])
            return SDWL_K_MAIN;
        else
            return SDWL_K_SYS;
    endfunction

    function automatic logic [CH_W-1:0] word_chan(
        input logic [WORD_W-1:0] w);
        return w[CH_LSB +: CH_W];
    endfunction

    // ==========================================================
    // link domain: shifter on the falling serial clock
    logic              link_rst;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [WORD_W-1:0] word_r;
    logic              tog_r;
    logic              last_bit;

    // reset reaches the link side through two flops; the link clock only
    // runs inside frames, so reset is seen on the first edges of a frame
    sdwl_sync u_rst_sync (
        .clk  (link.serial_clock_in),
        .din  (reset),
        .dout (link_rst)
    );

    // new bit enters at the bottom, so the first bit lands on top
    assign shift_nxt = {shift_r[WORD_W-2:0], link.serial_data_in};
    assign last_bit  = (cnt_r == CNT_W'(WORD_W - 1));

    // the link clock stands still between frames, so only the frame's
    // high level can restart the count; a reset that lifts inside a
    // frame must not eat the leading bits of the next word
    always_ff @(negedge link.serial_clock_in
                or posedge link.frame_sync_n) begin
        if (link.frame_sync_n)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + CNT_W'(1);
    end

    // every bit is overwritten within a word, so no reset is needed
    always_ff @(negedge link.serial_clock_in) begin
        if (!link.frame_sync_n)
            shift_r <= shift_nxt;
    end

    // completed word is held until the next one, long enough for the
    // toggle to cross; a byte-wise host's pause only stretches the frame
    always_ff @(negedge link.serial_clock_in) begin
        if (link_rst) begin
            word_r <= '0;
            tog_r  <= 1'b0;
        end else if (!link.frame_sync_n && last_bit) begin
            word_r <= shift_nxt;
            tog_r  <= ~tog_r;
        end
    end

    // ==========================================================
    // crossings into the system clock domain
    logic tog_s;
    logic tog_d_r;
    logic load_n_s;
    logic clear_n_s;
    logic new_word;

    sdwl_sync u_tog_sync (
        .clk  (clock),
        .din  (tog_r),
        .dout (tog_s)
    );

    sdwl_sync u_load_sync (
        .clk  (clock),
        .din  (link.output_load_strobe_n),
        .dout (load_n_s)
    );

    sdwl_sync u_clr_sync (
        .clk  (clock),
        .din  (link.hard_clear_n),
        .dout (clear_n_s)
    );

    always_ff @(posedge clock) begin
        if (reset)
            tog_d_r <= 1'b0;
        else
            tog_d_r <= tog_s;
    end

    assign new_word = tog_s ^ tog_d_r;

    // ==========================================================
    // word decode
    sdwl_kind_e        kind;
    logic [CH_W-1:0]   chan;
    logic [MAIN_W-1:0] main_payload;
    logic [FINE_W-1:0] fine_payload;
    logic [SYS_W-1:0]  sys_payload;
    logic              wr_sys;
    logic              wr_chan;
    logic              wr_main;
    logic              wr_fine;

    assign kind         = word_kind(word_r);
    assign chan         = word_chan(word_r);
    assign main_payload = word_r[MAIN_W-1:0];
    assign fine_payload = word_r[FINE_W-1:0];
    assign sys_payload  = word_r[SYS_W-1:0];
    assign wr_sys  = new_word && (kind == SDWL_K_SYS);
    assign wr_chan = new_word && (kind == SDWL_K_CHAN);
    assign wr_main = new_word && (kind == SDWL_K_MAIN);
    assign wr_fine = new_word && (kind == SDWL_K_FINE);

    // ==========================================================
    // system control register
    logic [SYS_W-1:0] sys_r;

    always_ff @(posedge clock) begin
        if (reset)
            sys_r <= SYS_RESET;
        else if (wr_sys)
            sys_r <= sys_payload;
    end

    assign offset_binary = sys_r[SYS_OFFBIN_BIT];
    assign standby       = sys_r[SYS_STANDBY_BIT];
    assign powerdown     = sys_r[SYS_PDOWN_BIT];

    // ==========================================================
    // per-channel input, output and control registers
    logic [MAIN_W-1:0] main_in_r  [NUM_CH];
    logic [FINE_W-1:0] fine_in_r  [NUM_CH];
    logic [MAIN_W-1:0] main_out_r [NUM_CH];
    logic [FINE_W-1:0] fine_out_r [NUM_CH];
    logic [MAIN_W-1:0] chan_r     [NUM_CH];
    logic              load_now;

    // a strobe held low makes every new main or fine code word reach the output
    // one cycle after it lands in the input register
    assign load_now = !load_n_s;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic hit;
        assign hit = (chan == CH_W'(c));

        // control word for this channel, e.g. reference selection
        always_ff @(posedge clock) begin
            if (reset)
                chan_r[c] <= CHAN_RESET;
            else if (wr_chan && hit)
                chan_r[c] <= main_payload;
        end

        // hard clear returns codes to midscale, the output centre
        always_ff @(posedge clock) begin
            if (reset || !clear_n_s) begin
                main_in_r[c] <= MAIN_MID;
                fine_in_r[c] <= FINE_MID;
            end else begin
                if (wr_main && hit)
                    main_in_r[c] <= main_payload;
                if (wr_fine && hit)
                    fine_in_r[c] <= fine_payload;
            end
        end

        always_ff @(posedge clock) begin
            if (reset || !clear_n_s) begin
                main_out_r[c] <= MAIN_MID;
                fine_out_r[c] <= FINE_MID;
            end else if (load_now) begin
                main_out_r[c] <= main_in_r[c];
                fine_out_r[c] <= fine_in_r[c];
            end
        end

        assign main_code_value[c] = main_out_r[c];
        assign fine_code_value[c] = fine_out_r[c];
        assign chan_ctrl[c]       = chan_r[c];
    end

    // ==========================================================
    // apply pulse
    logic applied_r;

    always_ff @(posedge clock) begin
        if (reset)
            applied_r <= 1'b0;
        else
            applied_r <= new_word;
    end

    assign word_applied = applied_r;
endmodule // sdwl_device

// *** logic/sdwl_host.sv ***
// host end: command registers and serial word transmitter
`timescale 1ns/100ps
module sdwl_host
    import sdwl_pkg::*;
(
    // system clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // command port
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [DATA_W-1:0] write_data,
    input  wire logic              write_strobe,
    input  wire logic              read_strobe,
    output logic      [DATA_W-1:0] read_data,
    // serial link
    sdwl_link_if.host              link
);
    typedef enum {SDWL_H_IDLE, SDWL_H_RISE, SDWL_H_FALL, SDWL_H_GAP,
                  SDWL_H_TAIL} sdwl_hstate_e;

    function automatic logic [WORD_W-1:0] bit_rev(
        input logic [WORD_W-1:0] w);
        for (int i = 0; i < WORD_W; i++)
            bit_rev[i] = w[WORD_W-1-i];
    endfunction

    // ==========================================================
    // command registers
    logic [CTRL_W-1:0] ctrl_r;
    logic [DATA_W-1:0] rd_r;
    logic              busy;
    logic              wr_data;
    logic              wr_ctrl;
    logic [DATA_W-1:0] rd_mux;

    assign wr_data = write_strobe && (address == HOST_DATA_OFS) && !busy;
    assign wr_ctrl = write_strobe && (address == HOST_CTRL_OFS);
    assign rd_mux  = (address == HOST_CTRL_OFS) ?
                         {{(DATA_W-CTRL_W){1'b0}}, ctrl_r} :
                     (address == HOST_STATUS_OFS) ?
                         {{(DATA_W-1){1'b0}}, busy} : '0;

    always_ff @(posedge clock) begin
        if (reset)
            ctrl_r <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl_r <= write_data[CTRL_W-1:0];
    end

    always_ff @(posedge clock) begin
        if (reset)
            rd_r <= '0;
        else
            rd_r <= read_strobe ? rd_mux : '0;
    end

    assign read_data = rd_r;
    assign link.output_load_strobe_n = ctrl_r[CTRL_LOAD_N_BIT];
    assign link.hard_clear_n         = ctrl_r[CTRL_CLEAR_N_BIT];

    // ==========================================================
    // transmitter: clock divided from the system clock
    sdwl_hstate_e      st_r;
    logic [PH_W-1:0]   ph_r;
    logic [CNT_W:0]    bits_r;
    logic [WORD_W-1:0] sh_r;
    logic              sclk_r;
    logic              sdat_r;
    logic              fs_n_r;
    logic              ph_end;
    logic              gap_end;
    logic              byte_pause;

    assign busy       = (st_r != SDWL_H_IDLE);
    assign ph_end     = (ph_r == HALF_CYC - PH_W'(1));
    assign gap_end    = (ph_r == GAP_CYC - PH_W'(1));
    assign byte_pause = ctrl_r[CTRL_BYTE_BIT] &&
                        (bits_r == (CNT_W+1)'(BYTE_W));

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r   <= SDWL_H_IDLE;
            ph_r   <= '0;
            bits_r <= '0;
            sh_r   <= '0;
            sclk_r <= 1'b0;
            sdat_r <= 1'b0;
            fs_n_r <= 1'b1;
        end else begin
            ph_r <= ph_r + PH_W'(1);
            unique case (st_r)
                SDWL_H_IDLE: begin
                    ph_r <= '0;
                    if (wr_data) begin
                        // lsb-first sources are reversed before sending
                        sh_r   <= ctrl_r[CTRL_LSBF_BIT] ?
                                  bit_rev(write_data[WORD_W-1:0]) :
                                  write_data[WORD_W-1:0];
                        bits_r <= '0;
                        fs_n_r <= 1'b0;
                        st_r   <= SDWL_H_FALL;
                        ph_r   <= HALF_CYC - PH_W'(1);
                    end
                end
                SDWL_H_RISE: if (ph_end) begin
                    ph_r   <= '0;
                    sclk_r <= 1'b0;
                    bits_r <= bits_r + (CNT_W+1)'(1);
                    st_r   <= SDWL_H_FALL;
                end
                SDWL_H_FALL: if (ph_end) begin
                    ph_r <= '0;
                    if (bits_r == (CNT_W+1)'(WORD_W)) begin
                        st_r <= SDWL_H_TAIL;
                    end else if (byte_pause && st_r != SDWL_H_GAP &&
                                 sclk_r == 1'b0 && ph_r != GAP_CYC) begin
                        st_r <= SDWL_H_GAP;
                    end else begin
                        // data changes with the rising edge so that it is
                        // settled when the dac samples on the fall
                        sclk_r <= 1'b1;
                        sdat_r <= sh_r[WORD_W-1];
                        sh_r   <= {sh_r[WORD_W-2:0], 1'b0};
                        st_r   <= SDWL_H_RISE;
                    end
                end
                SDWL_H_GAP: if (gap_end) begin
                    ph_r   <= '0;
                    sclk_r <= 1'b1;
                    sdat_r <= sh_r[WORD_W-1];
                    sh_r   <= {sh_r[WORD_W-2:0], 1'b0};
                    st_r   <= SDWL_H_RISE;
                end
                SDWL_H_TAIL: if (ph_end) begin
                    fs_n_r <= 1'b1;
                    st_r   <= SDWL_H_IDLE;
                end
            endcase
        end
    end

    assign link.serial_clock_in = sclk_r;
    assign link.serial_data_in  = sdat_r;
    assign link.frame_sync_n    = fs_n_r;
endmodule // sdwl_host

// *** tb/sdwl_link_sva.sv ***
// checker: link timing assertions for the serial dac word loader
`timescale 1ns/100ps
module sdwl_link_sva (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // serial link
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic frame_sync_n,
    input wire logic output_load_strobe_n,
    input wire logic hard_clear_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ==========================================================
    // falling serial edges seen inside the current frame
    logic [4:0] fall_cnt_r;
    always_ff @(posedge clock) begin
        if (reset || frame_sync_n)
            fall_cnt_r <= 5'h00;
        else if ($fell(serial_clock_in))
            fall_cnt_r <= fall_cnt_r + 5'h01;
    end
    // ==========================================================
    // link assertions
    chk_sclk_idle_low: assert property (
        frame_sync_n |-> !serial_clock_in)
        else $error("serial clock high outside a frame");
    chk_data_at_rise: assert property (
        !frame_sync_n && !$past(frame_sync_n) && $changed(serial_data_in)
        |-> $rose(serial_clock_in))
        else $error("data changed away from a rising serial edge");
    chk_fall_stable: assert property (
        $fell(serial_clock_in) |-> $stable(serial_data_in))
        else $error("data moved at a falling serial edge");
    chk_sclk_high_len: assert property (
        $rose(serial_clock_in) |-> serial_clock_in[*2] ##1 !serial_clock_in)
        else $error("serial clock high phase wrong");
    chk_sclk_low_len: assert property (
        $fell(serial_clock_in) && !frame_sync_n |-> !serial_clock_in[*2])
        else $error("serial clock low phase too short");
    chk_sixteen_falls: assert property (
        $rose(frame_sync_n) |-> fall_cnt_r == 5'h10)
        else $error("frame did not carry sixteen falling edges");
    chk_frame_length: assert property (
        $fell(frame_sync_n) |-> ##[64:100] $rose(frame_sync_n))
        else $error("frame length out of range");
    chk_reset_idle: assert property (
        $fell(reset) |-> frame_sync_n && !serial_clock_in
        && output_load_strobe_n && hard_clear_n)
        else $error("link not idle after reset");
    cover property ($rose(frame_sync_n));
    cover property ($fell(output_load_strobe_n));
    cover property ($fell(hard_clear_n));
endmodule // sdwl_link_sva

// *** tb/tb_top.sv ***
// testbench: host and dac ends joined, word loading checked
`timescale 1ns/100ps
module tb_top;
    import sdwl_pkg::*;
    // ==========================================================
    // signals
    logic              clock, reset, dev_reset;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] write_data, read_data, rd_v;
    logic              write_strobe, read_strobe;
    logic [MAIN_W-1:0] main_v [NUM_CH];
    logic [FINE_W-1:0] fine_v [NUM_CH];
    logic [MAIN_W-1:0] cc_v [NUM_CH];
    logic              offbin, stby, pdown, applied, lsbf_on;
    int                n_fail, n_tests, cyc;
    logic [31:0]       seed;
    logic [15:0]       exp_word, cap, w;
    logic [MAIN_W-1:0] exp_main [NUM_CH];
    logic [FINE_W-1:0] exp_fine [NUM_CH];
    sdwl_link_if link_if ();
    sdwl_host sdwl_host_inst (.clock(clock), .reset(reset),
        .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .link(link_if.host));
    // the dac end has its own reset so a dummy frame can clock it into the link side
    sdwl_device sdwl_device_inst (.clock(clock), .reset(dev_reset),
        .link(link_if.dac), .main_code_value(main_v),
        .fine_code_value(fine_v), .chan_ctrl(cc_v), .offset_binary(offbin),
        .standby(stby), .powerdown(pdown), .word_applied(applied));
    sdwl_link_sva sdwl_link_sva_inst (.clock(clock), .reset(reset),
        .serial_clock_in(link_if.serial_clock_in),
        .serial_data_in(link_if.serial_data_in),
        .frame_sync_n(link_if.frame_sync_n),
        .output_load_strobe_n(link_if.output_load_strobe_n),
        .hard_clear_n(link_if.hard_clear_n));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // an lsb-first source hands over the word in reversed bit order
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++)
            rev16[i] = v[15 - i];
    endfunction
    function automatic void upd(input logic [15:0] v);
        if (v[TYPE_FINE_BIT])
            exp_fine[v[CH_LSB +: CH_W]] = v[FINE_W-1:0];
        else if (v[TYPE_MAIN_BIT])
            exp_main[v[CH_LSB +: CH_W]] = v[MAIN_W-1:0];
    endfunction
    task automatic end_sim();
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_all();
        for (int c = 0; c < NUM_CH; c++) begin
            check(16'(main_v[c]), 16'(exp_main[c]));
            check(16'(fine_v[c]), 16'(exp_fine[c]));
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 rd_v = read_data;
    endtask
    task automatic send(input logic [15:0] v);
        logic seen;
        seen = 1'b0;
        exp_word = lsbf_on ? rev16(v) : v;
        wr(HOST_DATA_OFS, {16'h0000, v});
        for (int i = 0; i < 200 && !seen; i++) begin
            @(negedge clock);
            seen = (applied === 1'b1);
        end
        check({15'h0000, seen}, 16'h0001);
        repeat (3) @(posedge clock);
    endtask
    // ==========================================================
    // wire monitor: rebuild each word from falling serial edges
    always @(negedge link_if.serial_clock_in)
        if (link_if.frame_sync_n === 1'b0)
            cap = {cap[14:0], link_if.serial_data_in};
    always @(posedge link_if.frame_sync_n)
        if (reset === 1'b0)
            check(cap, exp_word);
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        reset = 1'b1;
        dev_reset = 1'b1;
        address = '0;
        write_data = '0;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        n_fail = 0;
        n_tests = 0;
        cyc = 0;
        exp_word = '0;
        cap = '0;
        w = '0;
        lsbf_on = 1'b0;
        seed = 32'h0000C19A;
        for (int c = 0; c < NUM_CH; c++) begin
            exp_main[c] = MAIN_MID;
            exp_fine[c] = FINE_MID;
        end
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        wr(HOST_DATA_OFS, 32'h00000000);
        repeat (4) @(posedge clock);
        for (int i = 0; i < 100; i++) begin
            rd(HOST_STATUS_OFS);
            if (rd_v[0] === 1'b0)
                break;
        end
        check(rd_v[15:0], 16'h0000);
        dev_reset <= 1'b0;
        repeat (4) @(posedge clock);
        check_all();
        rd(HOST_CTRL_OFS);
        check(rd_v[15:0], {12'h000, CTRL_RESET});
        rd(4'hC);
        check(rd_v[15:0], 16'h0000);
        send(16'h0060);
        check({13'h0000, offbin, stby, pdown}, 16'h0004);
        send(16'h4210);
        check(16'(cc_v[0]), 16'h0210);
        // load strobe still high: the output must hold its old code
        send(16'h23FF);
        check(16'(main_v[0]), 16'(MAIN_MID));
        wr(HOST_CTRL_OFS, 32'h00000002);
        repeat (6) @(posedge clock);
        exp_main[0] = 10'h3FF;
        check(16'(main_v[0]), 16'h03FF);
        for (int i = 0; i < 24; i++) begin
            if (i == 12)
                wr(HOST_CTRL_OFS, 32'h0000000A);
            seed = xs(seed);
            w = {seed[0], 1'b0, ~seed[0], seed[12:0]};
            if (i < 3)
                w = (i == 0) ? 16'hA3FF : (i == 1) ? 16'h3C00 : 16'h9C00;
            upd(w);
            send(w);
            check_all();
        end
        // lsb-first source: host reverses, the dac still sees msb first
        wr(HOST_CTRL_OFS, 32'h00000006);
        lsbf_on = 1'b1;
        upd(16'h2555);
        send(rev16(16'h2555));
        check_all();
        lsbf_on = 1'b0;
        // clear must win over a load strobe held low
        wr(HOST_CTRL_OFS, 32'h00000000);
        repeat (6) @(posedge clock);
        for (int c = 0; c < NUM_CH; c++) begin
            exp_main[c] = MAIN_MID;
            exp_fine[c] = FINE_MID;
        end
        check_all();
        wr(HOST_CTRL_OFS, 32'h00000003);
        end_sim();
    end
endmodule // tb_top
